// ===== motion_status_output_regs.sv
// The address map and register access over AXI4-Lite are this design's own decisions.
`include "motion_status_consts.svh"

module motion_status_output_regs
  import motion_status_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  // AXI4-Lite slave
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // Drive datapath state, same clock
  input  wire logic        DRIVE_BUSY,
  input  wire logic        HOME_SEARCH_BUSY,
  input  wire logic        ACCELERATING_FLAG,
  input  wire logic        CONSTANT_SPEED_FLAG,
  input  wire logic        DECELERATING_FLAG,
  input  wire logic        RATE_RISING_FLAG,
  input  wire logic        RATE_FALLING_FLAG,
  input  wire logic        TIMER_RUNNING,
  input  wire logic        SPLIT_RUNNING,
  input  wire logic        SOFT_PLUS_REACHED,
  input  wire logic        SOFT_MINUS_BELOW,
  input  wire logic        LINKED_STOP,
  // Interrupt event pulses, same clock
  input  wire logic [3:0]  COMPARE_MATCH_CAUSES,
  input  wire logic        DRIVE_START_CAUSE,
  input  wire logic        CONST_ENTRY_CAUSE,
  input  wire logic        CONST_EXIT_CAUSE,
  input  wire logic        DRIVE_END_CAUSE,
  input  wire logic        HOME_END_CAUSE,
  input  wire logic        TIMER_EXPIRY_CAUSE,
  input  wire logic        SPLIT_EDGE_CAUSE,
  input  wire logic        SPLIT_DONE_CAUSE,
  // Asynchronous pins
  input  wire logic        PLUS_LIMIT_INPUT,
  input  wire logic        MINUS_LIMIT_INPUT,
  input  wire logic        ALARM_INPUT,
  input  wire logic        EMERGENCY_INPUT_N,
  input  wire logic [2:0]  EXTERNAL_HALT_INPUTS,
  // Outputs
  output logic [7:0]       GENERAL_IO_PINS,
  output logic [31:0]      OPERAND_BITS,
  output logic             DRIVE_START_PLUS,
  output logic             DRIVE_START_MINUS,
  output logic             STOP_INSTANT,
  output logic             STOP_DECEL,
  output logic             INTERRUPT_OUT_N
);

  // ---------------- Pin synchronisers ----------------
  logic [6:0] pin_raw;                       // Raw pin levels
  logic [6:0] pin_lvl_reg;                   // Accepted levels
  logic [6:0] pin_lvl_next;
  logic [6:0] sync1_reg, sync2_reg, sync3_reg;

  assign pin_raw = {EXTERNAL_HALT_INPUTS, EMERGENCY_INPUT_N, ALARM_INPUT,
                    MINUS_LIMIT_INPUT, PLUS_LIMIT_INPUT};

  // A level is accepted only once stages two and three agree, which
  // rejects a one-cycle glitch on a noisy limit switch
  localparam logic [6:0] pin_rst_lvl = `RST_PIN_LEVELS;  // Idle pin levels, emergency pin high
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_pin
      always_comb begin
        pin_lvl_next[gi] = (sync2_reg[gi] == sync3_reg[gi]) ? sync2_reg[gi] : pin_lvl_reg[gi];
      end
      always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
          sync1_reg[gi]   <= pin_rst_lvl[gi];
          sync2_reg[gi]   <= pin_rst_lvl[gi];
          sync3_reg[gi]   <= pin_rst_lvl[gi];
          pin_lvl_reg[gi] <= pin_rst_lvl[gi];
        end else begin
          sync1_reg[gi]   <= pin_raw[gi];
          sync2_reg[gi]   <= sync1_reg[gi];
          sync3_reg[gi]   <= sync2_reg[gi];
          pin_lvl_reg[gi] <= pin_lvl_next[gi];
        end
      end
    end
  endgenerate

  logic plus_lim, minus_lim, alarm_act, emg_act;
  logic [2:0] halt_act;
  assign plus_lim  = pin_lvl_reg[`PIN_PLUS_LIMIT];
  assign minus_lim = pin_lvl_reg[`PIN_MINUS_LIMIT];
  assign alarm_act = pin_lvl_reg[`PIN_ALARM];
  assign emg_act   = ~pin_lvl_reg[`PIN_EMERGENCY_N];  // Pin is active low
  assign halt_act  = pin_lvl_reg[`PIN_HALT_LSB +: 3];

  // ---------------- AXI4-Lite slave ----------------
  logic        awready_reg, awready_next;    // Address slot free
  logic        wready_reg, wready_next;      // Data slot free
  logic [7:0]  awaddr_reg, awaddr_next;      // Held write address
  logic [31:0] wdata_reg, wdata_next;        // Held write data
  logic [3:0]  wstrb_reg, wstrb_next;        // Held byte strobes
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        arready_reg, arready_next;
  logic        rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic        wr_do;                        // Both halves held, commit now
  logic        rd_do;                        // Read address taken now
  logic        wr_hit;                       // Write address is a writable register

  assign wr_do = !awready_reg && !wready_reg && !bvalid_reg;
  assign rd_do = S_AXI_ARVALID && arready_reg;

  // Address and data are caught in either order; a slot closes once
  // filled and both reopen only after the response is taken
  always_comb begin
    awready_next = awready_reg;
    wready_next  = wready_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    if (S_AXI_AWVALID && awready_reg) begin
      awaddr_next  = S_AXI_AWADDR;
      awready_next = 1'b0;
    end
    if (S_AXI_WVALID && wready_reg) begin
      wdata_next  = S_AXI_WDATA;
      wstrb_next  = S_AXI_WSTRB;
      wready_next = 1'b0;
    end
    if (wr_do) begin
      bvalid_next = 1'b1;
      bresp_next  = wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (bvalid_reg && S_AXI_BREADY) begin
      bvalid_next  = 1'b0;
      awready_next = 1'b1;
      wready_next  = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `AXI_RESP_OKAY;
    end else begin
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
    end
  end

  // ---------------- Register file ----------------
  logic [7:0]  gen_out_reg, gen_out_next;    // Output latch
  logic [31:0] operand_reg, operand_next;    // Staged command operand
  word16_t     int_en_reg, int_en_next;      // Factor enables
  logic [4:0]  lim_ctl_reg, lim_ctl_next;    // Limit enables and stop types
  logic [3:0]  link_en_reg, link_en_next;    // Linked-action units enabled
  word16_t     cause_reg, cause_next;        // Interrupt factors
  word16_t     err_fin_reg, err_fin_next;    // Error and finish record
  logic        drv_minus_reg, drv_minus_next;  // Direction of current drive
  logic        start_p_reg, start_p_next;
  logic        start_m_reg, start_m_next;
  logic        stop_i_reg, stop_i_next;
  logic        stop_d_reg, stop_d_next;
  logic        irq_n_reg, irq_n_next;
  word16_t     main_status;                  // Live main status word
  word16_t     events;                       // Raw factor events this cycle
  word16_t     rd_clear;                     // Cause bits cleared by this read
  word16_t     cmd;                          // Command word when written
  logic        driving;
  logic        refuse_p, refuse_m;           // Start blocked by active limit
  logic        soft_p, soft_m, hard_p, hard_m, alm_hit, emg_hit;

  assign driving = DRIVE_BUSY || HOME_SEARCH_BUSY;
  assign cmd = (wr_do && awaddr_reg == `ADDR_COMMAND) ? wdata_reg[15:0] : 16'h0000;

  // Error detection only while driving and only toward the limit's side
  assign soft_p  = driving && !drv_minus_reg && lim_ctl_reg[`CTL_SOFT_LIMIT_EN] && SOFT_PLUS_REACHED;
  assign soft_m  = driving && drv_minus_reg && lim_ctl_reg[`CTL_SOFT_LIMIT_EN] && SOFT_MINUS_BELOW;
  assign hard_p  = driving && !drv_minus_reg && lim_ctl_reg[`CTL_HARD_LIMIT_EN] && plus_lim;
  assign hard_m  = driving && drv_minus_reg && lim_ctl_reg[`CTL_HARD_LIMIT_EN] && minus_lim;
  assign alm_hit = driving && lim_ctl_reg[`CTL_ALARM_EN] && alarm_act;
  assign emg_hit = driving && emg_act;

  // A start toward a still-active limit is refused and errs again
  assign refuse_p = (lim_ctl_reg[`CTL_HARD_LIMIT_EN] && plus_lim)
                 || (lim_ctl_reg[`CTL_SOFT_LIMIT_EN] && SOFT_PLUS_REACHED);
  assign refuse_m = (lim_ctl_reg[`CTL_HARD_LIMIT_EN] && minus_lim)
                 || (lim_ctl_reg[`CTL_SOFT_LIMIT_EN] && SOFT_MINUS_BELOW);

  assign events = {4'h0, SPLIT_DONE_CAUSE, SPLIT_EDGE_CAUSE, TIMER_EXPIRY_CAUSE, HOME_END_CAUSE,
                   DRIVE_END_CAUSE, CONST_EXIT_CAUSE, CONST_ENTRY_CAUSE, DRIVE_START_CAUSE,
                   COMPARE_MATCH_CAUSES};

  assign main_status = {2'b00, SPLIT_RUNNING, TIMER_RUNNING, link_en_reg, RATE_FALLING_FLAG, 1'b0,
                        RATE_RISING_FLAG, DECELERATING_FLAG, CONSTANT_SPEED_FLAG, ACCELERATING_FLAG,
                        |err_fin_reg[6:0], driving};

  // Read-clear masks: whole word, or one byte as an 8-bit host would
  always_comb begin
    rd_clear = 16'h0000;
    if (rd_do) begin
      unique case (S_AXI_ARADDR)
        `ADDR_INTERRUPT_CAUSE:      rd_clear = 16'hffff;
        `ADDR_INTERRUPT_CAUSE_LOW:  rd_clear = 16'h00ff;
        `ADDR_INTERRUPT_CAUSE_HIGH: rd_clear = 16'hff00;
        default:                    rd_clear = 16'h0000;
      endcase
    end
  end

  // Write decode, command actions, sticky status and interrupt
  always_comb begin
    wr_hit         = 1'b1;
    gen_out_next   = gen_out_reg;
    operand_next   = operand_reg;
    int_en_next    = int_en_reg;
    lim_ctl_next   = lim_ctl_reg;
    link_en_next   = link_en_reg;
    err_fin_next   = err_fin_reg;
    drv_minus_next = drv_minus_reg;
    start_p_next   = 1'b0;
    start_m_next   = 1'b0;
    stop_i_next    = 1'b0;
    stop_d_next    = 1'b0;
    unique case (awaddr_reg)
      `ADDR_GENERAL_OUTPUT_LEVEL: begin
        // Upper byte is not stored; host keeps it zero
        if (wr_do && wstrb_reg[0]) begin
          gen_out_next = wdata_reg[7:0];
        end
      end
      `ADDR_OPERAND_LOW_WORD: begin
        for (int b = 0; b < 2; b++) begin
          if (wr_do && wstrb_reg[b]) begin
            operand_next[8*b +: 8] = wdata_reg[8*b +: 8];
          end
        end
      end
      `ADDR_OPERAND_HIGH_WORD: begin
        for (int b = 0; b < 2; b++) begin
          if (wr_do && wstrb_reg[b]) begin
            operand_next[16 + 8*b +: 8] = wdata_reg[8*b +: 8];
          end
        end
      end
      `ADDR_INTERRUPT_ENABLE: begin
        for (int b = 0; b < 2; b++) begin
          if (wr_do && wstrb_reg[b]) begin
            int_en_next[8*b +: 8] = wdata_reg[8*b +: 8];
          end
        end
      end
      `ADDR_LIMIT_CONTROL: begin
        if (wr_do && wstrb_reg[0]) begin
          lim_ctl_next = wdata_reg[4:0];
        end
      end
      `ADDR_COMMAND: begin
        // Command takes effect below through cmd
      end
      default: begin
        wr_hit = 1'b0;  // Unmapped or read-only address
      end
    endcase

    // Linked-action units: disable wins only when both are written
    link_en_next = (link_en_next | cmd[`CMD_LINK_EN_LSB +: 4]) & ~cmd[`CMD_LINK_DIS_LSB +: 4];

    // Clear command wipes the record before new causes are merged
    if (cmd[`CMD_CLEAR_ERR_FINISH]) begin
      err_fin_next = 16'h0000;
    end

    // Start commands when not driving: refused toward an active limit, else launched
    if (cmd[`CMD_START_PLUS] && !driving) begin
      if (refuse_p) begin
        err_fin_next[0] = err_fin_next[0] | (lim_ctl_reg[`CTL_SOFT_LIMIT_EN] && SOFT_PLUS_REACHED);
        err_fin_next[2] = err_fin_next[2] | (lim_ctl_reg[`CTL_HARD_LIMIT_EN] && plus_lim);
      end else begin
        err_fin_next   = 16'h0000;
        drv_minus_next = 1'b0;
        start_p_next   = 1'b1;
      end
    end else if (cmd[`CMD_START_MINUS] && !driving) begin
      if (refuse_m) begin
        err_fin_next[1] = err_fin_next[1] | (lim_ctl_reg[`CTL_SOFT_LIMIT_EN] && SOFT_MINUS_BELOW);
        err_fin_next[3] = err_fin_next[3] | (lim_ctl_reg[`CTL_HARD_LIMIT_EN] && minus_lim);
      end else begin
        err_fin_next   = 16'h0000;
        drv_minus_next = 1'b1;
        start_m_next   = 1'b1;
      end
    end

    // Causes during a drive set sticky bits; a set beats a same-cycle clear
    err_fin_next = err_fin_next | {emg_hit, alm_hit, hard_m, hard_p,
                                   driving ? halt_act : 3'b000,
                                   driving && LINKED_STOP,
                                   2'b00, emg_hit, alm_hit, hard_m, hard_p, soft_m, soft_p};

    // Stop requests to the pulse generator; instant beats decelerating
    if (emg_hit || alm_hit
        || ((hard_p || hard_m) && !lim_ctl_reg[`CTL_HARD_LIMIT_STOP_TYPE])
        || ((soft_p || soft_m) && lim_ctl_reg[`CTL_SOFT_LIMIT_STOP_TYPE])) begin
      stop_i_next = 1'b1;
    end else if (hard_p || hard_m || soft_p || soft_m) begin
      stop_d_next = 1'b1;
    end

    // Factor bits: enabled events only, set wins over read clear
    cause_next = (cause_reg & ~rd_clear) | (events & int_en_reg);
    irq_n_next = ~|cause_next;
  end

  // Operand staging carries no reset, so its value is unknown until written
  always_ff @(posedge SYS_CLK) begin
    operand_reg <= operand_next;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      gen_out_reg   <= `RST_GENERAL_OUTPUT;
      int_en_reg    <= `RST_INTERRUPT_ENABLE;
      lim_ctl_reg   <= `RST_LIMIT_CONTROL;
      link_en_reg   <= 4'h0;
      cause_reg     <= 16'h0000;
      err_fin_reg   <= 16'h0000;
      drv_minus_reg <= 1'b0;
      start_p_reg   <= 1'b0;
      start_m_reg   <= 1'b0;
      stop_i_reg    <= 1'b0;
      stop_d_reg    <= 1'b0;
      irq_n_reg     <= 1'b1;
    end else begin
      gen_out_reg   <= gen_out_next;
      int_en_reg    <= int_en_next;
      lim_ctl_reg   <= lim_ctl_next;
      link_en_reg   <= link_en_next;
      cause_reg     <= cause_next;
      err_fin_reg   <= err_fin_next;
      drv_minus_reg <= drv_minus_next;
      start_p_reg   <= start_p_next;
      start_m_reg   <= start_m_next;
      stop_i_reg    <= stop_i_next;
      stop_d_reg    <= stop_d_next;
      irq_n_reg     <= irq_n_next;
    end
  end

  // ---------------- Read channel ----------------
  // One read in flight; the address is refused while data waits
  always_comb begin
    arready_next = arready_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (rd_do) begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      rresp_next   = `AXI_RESP_OKAY;
      unique case (S_AXI_ARADDR)
        `ADDR_GENERAL_OUTPUT_LEVEL: rdata_next = {24'h000000, gen_out_reg};
        `ADDR_OPERAND_LOW_WORD:     rdata_next = 32'h0000_0000;  // Write-only
        `ADDR_OPERAND_HIGH_WORD:    rdata_next = 32'h0000_0000;  // Write-only
        `ADDR_MAIN_DRIVE_STATUS:    rdata_next = {16'h0000, main_status};
        `ADDR_INTERRUPT_CAUSE:      rdata_next = {16'h0000, cause_reg};
        `ADDR_INTERRUPT_CAUSE_LOW:  rdata_next = {24'h000000, cause_reg[7:0]};
        `ADDR_INTERRUPT_CAUSE_HIGH: rdata_next = {24'h000000, cause_reg[15:8]};
        `ADDR_ERROR_FINISH_STATUS:  rdata_next = {16'h0000, err_fin_reg};
        `ADDR_INTERRUPT_ENABLE:     rdata_next = {16'h0000, int_en_reg};
        `ADDR_LIMIT_CONTROL:        rdata_next = {27'h0000000, lim_ctl_reg};
        `ADDR_COMMAND:              rdata_next = 32'h0000_0000;
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = `AXI_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= `AXI_RESP_OKAY;
    end else begin
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  // ---------------- Outputs, all from flip-flops ----------------
  assign S_AXI_AWREADY     = awready_reg;
  assign S_AXI_WREADY      = wready_reg;
  assign S_AXI_BVALID      = bvalid_reg;
  assign S_AXI_BRESP       = bresp_reg;
  assign S_AXI_ARREADY     = arready_reg;
  assign S_AXI_RVALID      = rvalid_reg;
  assign S_AXI_RDATA       = rdata_reg;
  assign S_AXI_RRESP       = rresp_reg;
  assign GENERAL_IO_PINS   = gen_out_reg;
  assign OPERAND_BITS      = operand_reg;
  assign DRIVE_START_PLUS  = start_p_reg;
  assign DRIVE_START_MINUS = start_m_reg;
  assign STOP_INSTANT      = stop_i_reg;
  assign STOP_DECEL        = stop_d_reg;
  assign INTERRUPT_OUT_N   = irq_n_reg;

endmodule // motion_status_output_regs

// ===== motion_status_consts.svh
`ifndef MOTION_STATUS_CONSTS_SVH
`define MOTION_STATUS_CONSTS_SVH

// Register byte offsets on the AXI4-Lite slave
`define ADDR_GENERAL_OUTPUT_LEVEL   8'h00
`define ADDR_OPERAND_LOW_WORD       8'h04
`define ADDR_OPERAND_HIGH_WORD      8'h08
`define ADDR_MAIN_DRIVE_STATUS      8'h0c
`define ADDR_INTERRUPT_CAUSE        8'h10
`define ADDR_INTERRUPT_CAUSE_LOW    8'h14
`define ADDR_INTERRUPT_CAUSE_HIGH   8'h18
`define ADDR_ERROR_FINISH_STATUS    8'h1c
`define ADDR_INTERRUPT_ENABLE       8'h20
`define ADDR_LIMIT_CONTROL          8'h24
`define ADDR_COMMAND                8'h28

// Reset values
`define RST_GENERAL_OUTPUT          8'h00
`define RST_INTERRUPT_ENABLE        16'h0000
`define RST_LIMIT_CONTROL           5'h00
`define RST_PIN_LEVELS              7'h08

// Limit control fields
`define CTL_SOFT_LIMIT_EN           0
`define CTL_HARD_LIMIT_EN           1
`define CTL_ALARM_EN                2
`define CTL_HARD_LIMIT_STOP_TYPE    3
`define CTL_SOFT_LIMIT_STOP_TYPE    4

// Command fields (write one to act)
`define CMD_CLEAR_ERR_FINISH        0
`define CMD_START_PLUS              1
`define CMD_START_MINUS             2
`define CMD_LINK_EN_LSB             8
`define CMD_LINK_DIS_LSB            12

// Pin synchroniser bit positions
`define PIN_PLUS_LIMIT              0
`define PIN_MINUS_LIMIT             1
`define PIN_ALARM                   2
`define PIN_EMERGENCY_N             3
`define PIN_HALT_LSB                4

// AXI responses
`define AXI_RESP_OKAY               2'b00
`define AXI_RESP_SLVERR             2'b10

`endif

// ===== motion_status_pkg.sv
package motion_status_pkg;
  typedef logic [15:0] word16_t;   // One host register word
  typedef logic [1:0]  axi_resp_t; // AXI response code
endpackage

// ===== motion_status_output_regs_properties.sv
module motion_status_checker (
  input wire logic       SYS_CLK, RST_N, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY,
  input wire logic       S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID,
  input wire logic       DRIVE_BUSY, HOME_SEARCH_BUSY, DRIVE_START_PLUS, DRIVE_START_MINUS, STOP_INSTANT, STOP_DECEL,
  input wire logic [31:0] OPERAND_BITS,
  input wire logic [7:0] GENERAL_IO_PINS
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // Axis moving in either mode
  wire mv = DRIVE_BUSY || HOME_SEARCH_BUSY;
  property p_bv; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID; endproperty
  a_bv: assert property (p_bv) else $error("write answer late");
  property p_rv; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
  a_rv: assert property (p_rv) else $error("read answer late");
  property p_bq; S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY; endproperty
  a_bq: assert property (p_bq) else $error("write slot open during answer");
  property p_rq; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
  a_rq: assert property (p_rq) else $error("read slot open during answer");
  // Checked through reset, so it carries no disable
  property p_gio; disable iff (1'b0) !RST_N |=> GENERAL_IO_PINS == 8'h00; endproperty
  a_gio: assert property (p_gio) else $error("output latch not cleared");
  property p_commit; $changed(GENERAL_IO_PINS) || $changed(OPERAND_BITS) |-> $rose(S_AXI_BVALID); endproperty
  a_commit: assert property (p_commit) else $error("register changed off a write");
  property p_start; DRIVE_START_PLUS || DRIVE_START_MINUS |-> $rose(S_AXI_BVALID) && !$past(DRIVE_BUSY); endproperty
  a_start: assert property (p_start) else $error("start without command");
  // Two cycles of slack, as busy may be staged beside the pins
  property p_stop; STOP_INSTANT || STOP_DECEL |-> $past(mv) || $past(mv, 2); endproperty
  a_stop: assert property (p_stop) else $error("stop while axis idle");
  c_inst: cover property (STOP_INSTANT);
  c_decel: cover property (STOP_DECEL);
  c_start: cover property (DRIVE_START_PLUS);
endmodule // motion_status_checker
bind motion_status_output_regs motion_status_checker u_chk (.*);

// ===== axi_host_model.sv
module axi_host_model (
  input wire logic        SYS_CLK, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID,
  input wire logic [1:0]  S_AXI_BRESP, S_AXI_RRESP,
  input wire logic [31:0] S_AXI_RDATA,
  output logic [7:0]      S_AXI_AWADDR, S_AXI_ARADDR,
  output logic [31:0]     S_AXI_WDATA,
  output logic [3:0]      S_AXI_WSTRB,
  output logic            S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWADDR, S_AXI_WDATA} = '0;
  initial {S_AXI_ARADDR, S_AXI_WSTRB} = '0;
  // Released payload is inverted so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge SYS_CLK);
    {S_AXI_AWADDR, S_AXI_WDATA, S_AXI_WSTRB} <= {a, d, 4'hf};
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'b111;
    fork
      begin do @(posedge SYS_CLK); while (!S_AXI_AWREADY); {S_AXI_AWVALID, S_AXI_AWADDR} <= {1'b0, ~a}; end
      begin do @(posedge SYS_CLK); while (!S_AXI_WREADY); {S_AXI_WVALID, S_AXI_WDATA} <= {1'b0, ~d}; end
    join
    do @(posedge SYS_CLK); while (!S_AXI_BVALID);
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge SYS_CLK);
    {S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} <= {a, 2'b11};
    do @(posedge SYS_CLK); while (!S_AXI_ARREADY);
    {S_AXI_ARVALID, S_AXI_ARADDR} <= {1'b0, ~a};
    do @(posedge SYS_CLK); while (!S_AXI_RVALID);
    {d, r} = {S_AXI_RDATA, S_AXI_RRESP};
    S_AXI_RREADY <= 1'b0;
  endtask
endmodule // axi_host_model

// ===== tb_motion_status_output_regs.sv
`include "motion_status_consts.svh"
module tb_motion_status_output_regs import motion_status_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic SYS_CLK = 1'b0, RST_N = 1'b0, db = 1'b0, hb = 1'b0, pl = 1'b0, ml = 1'b0, sp = 1'b0, en_n = 1'b1;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR, GENERAL_IO_PINS;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, OPERAND_BITS, rv;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rs;
  logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID;
  logic S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, DRIVE_START_PLUS, DRIVE_START_MINUS, STOP_INSTANT;
  logic STOP_DECEL, INTERRUPT_OUT_N;
  logic [6:0] ph = '0;
  logic [11:0] ev = '0;
  int miscompares = 0, n_checks = 0;
  always #50 SYS_CLK = ~SYS_CLK;
  axi_host_model m (.*);
  motion_status_output_regs DUT (.*, .DRIVE_BUSY(db), .HOME_SEARCH_BUSY(hb), .ACCELERATING_FLAG(ph[0]),
    .CONSTANT_SPEED_FLAG(ph[1]), .DECELERATING_FLAG(ph[2]), .RATE_RISING_FLAG(ph[3]), .RATE_FALLING_FLAG(ph[4]),
    .TIMER_RUNNING(ph[5]), .SPLIT_RUNNING(ph[6]), .SOFT_PLUS_REACHED(sp), .SOFT_MINUS_BELOW(1'b0), .LINKED_STOP(1'b0),
    .COMPARE_MATCH_CAUSES(ev[3:0]), .DRIVE_START_CAUSE(ev[4]), .CONST_ENTRY_CAUSE(ev[5]), .CONST_EXIT_CAUSE(ev[6]),
    .DRIVE_END_CAUSE(ev[7]), .HOME_END_CAUSE(ev[8]), .TIMER_EXPIRY_CAUSE(ev[9]), .SPLIT_EDGE_CAUSE(ev[10]),
    .SPLIT_DONE_CAUSE(ev[11]), .PLUS_LIMIT_INPUT(pl), .MINUS_LIMIT_INPUT(ml), .ALARM_INPUT(1'b0),
    .EMERGENCY_INPUT_N(en_n), .EXTERNAL_HALT_INPUTS(3'h0));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic w(input int n); repeat (n) @(posedge SYS_CLK); endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d); m.wr(a, d, rs); endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e); m.rd(a, rv, rs); chk("rdata", e, rv); endtask
  task automatic pulse(input logic [11:0] x); @(posedge SYS_CLK); ev <= x; @(posedge SYS_CLK); ev <= '0; w(1); endtask
  // Latch, refused accesses and operand written high word first
  task automatic t_regs;
    wr(`ADDR_GENERAL_OUTPUT_LEVEL, 32'h0000_00a5);
    chk("gpio", 32'h0000_00a5, {24'h0, GENERAL_IO_PINS});
    wr(`ADDR_MAIN_DRIVE_STATUS, 32'h0);
    chk("bresp", {30'h0, `AXI_RESP_SLVERR}, {30'h0, rs});
    m.rd(8'h40, rv, rs);
    chk("rresp", {30'h0, `AXI_RESP_SLVERR}, {30'h0, rs});
    wr(`ADDR_OPERAND_HIGH_WORD, 32'h0000_fffe);
    wr(`ADDR_OPERAND_LOW_WORD, 32'h0000_8001);
    chk("operand", 32'hfffe_8001, OPERAND_BITS);
  endtask
  // Live phase flags and linked-action enables
  task automatic t_status;
    {db, ph} <= {1'b1, 7'h7f};
    wr(`ADDR_COMMAND, 32'h0f00);
    rc(`ADDR_MAIN_DRIVE_STATUS, 32'h3fbd);
    {db, hb, ph} <= {2'b01, 7'h00};
    wr(`ADDR_COMMAND, 32'hf000);
    rc(`ADDR_MAIN_DRIVE_STATUS, 32'h0001);
    hb <= 1'b0;
  endtask
  // Every cause bit, byte-wise clear and masking
  task automatic t_irq;
    wr(`ADDR_INTERRUPT_ENABLE, 32'h0fff);
    for (int i = 0; i < 12; i++) begin
      pulse(12'h001 << i);
      rc(`ADDR_INTERRUPT_CAUSE, 32'h1 << i);
    end
    chk("irq_n", 32'h1, {31'h0, INTERRUPT_OUT_N});
    pulse(12'h101);
    chk("irq_n", 32'h0, {31'h0, INTERRUPT_OUT_N});
    rc(`ADDR_INTERRUPT_CAUSE_LOW, 32'h1);
    chk("irq_n", 32'h0, {31'h0, INTERRUPT_OUT_N});
    rc(`ADDR_INTERRUPT_CAUSE_HIGH, 32'h1);
    chk("irq_n", 32'h1, {31'h0, INTERRUPT_OUT_N});
    wr(`ADDR_INTERRUPT_ENABLE, 32'h0080);
    pulse(12'hfff);
    rc(`ADDR_INTERRUPT_CAUSE, 32'h0080);
  endtask
  // Limits: pins need five cycles to reach the stop outputs
  task automatic t_err;
    wr(`ADDR_LIMIT_CONTROL, 32'h02);
    wr(`ADDR_COMMAND, 32'h02);
    {db, pl} <= 2'b11;
    w(7);
    chk("stop_inst", 32'h1, {31'h0, STOP_INSTANT});
    db <= 1'b0;
    w(2);
    rc(`ADDR_ERROR_FINISH_STATUS, 32'h1004);
    rc(`ADDR_MAIN_DRIVE_STATUS, 32'h0002);
    wr(`ADDR_COMMAND, 32'h03);
    rc(`ADDR_ERROR_FINISH_STATUS, 32'h0004);
    {pl, en_n} <= 2'b00;
    w(7);
    wr(`ADDR_COMMAND, 32'h01);
    rc(`ADDR_ERROR_FINISH_STATUS, 32'h0);
    en_n <= 1'b1;
    wr(`ADDR_LIMIT_CONTROL, 32'h03);
    wr(`ADDR_COMMAND, 32'h02);
    {db, ml, sp} <= 3'b111;
    w(7);
    chk("stop_decel", 32'h1, {31'h0, STOP_DECEL});
    chk("stop_inst", 32'h0, {31'h0, STOP_INSTANT});
    {db, ml, sp} <= 3'b000;
    w(2);
    rc(`ADDR_ERROR_FINISH_STATUS, 32'h0001);
    // Emergency pin during a plus drive: instant stop, error and finish bits
    wr(`ADDR_COMMAND, 32'h02);
    {db, en_n} <= 2'b10;
    w(7);
    chk("stop_inst", 32'h1, {31'h0, STOP_INSTANT});
    {db, en_n} <= 2'b01;
    w(2);
    rc(`ADDR_ERROR_FINISH_STATUS, 32'h8020);
  endtask
  task automatic report_and_stop;
    if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    w(3);
    RST_N <= 1'b1;
    w(1);
    t_regs;
    t_status;
    t_irq;
    t_err;
    report_and_stop;
  end
  // Whole run is a few hundred cycles; this allows far more
  initial begin
    #2_000_000;
    miscompares++;
    report_and_stop;
  end
endmodule // tb_motion_status_output_regs
